// ---- rtl/hmp_defs.svh ----
// Constants of the maximum-address security state machine
`ifndef HMP_DEFS_SVH
`define HMP_DEFS_SVH
`define HMP_OPC_SETMAX 8'hf9
`define HMP_OPC_SETMAX_EXT 8'h37
`define HMP_FEAT_PWSET 8'h01
`define HMP_FEAT_LOCK 8'h02
`define HMP_FEAT_UNLOCK 8'h03
`define HMP_FEAT_FREEZE 8'h04
`define HMP_PW_FIRST 8'h01
`define HMP_PW_WORDS 16
`define HMP_WORD_W 16
`define HMP_SECTOR_LAST 8'hff
`define HMP_TRY_W 3
`define HMP_TRY_LOAD 3'h5
`define HMP_TRY_ZERO 3'h0
`endif

// ---- rtl/hmp_pkg.sv ----
// Types of the maximum-address security state machine
package hmp_pkg;
    typedef enum logic [1:0] {
        SEC_OPEN = 2'b00,
        SEC_LOCKED = 2'b01,
        SEC_FROZEN = 2'b10
    } hmp_sec_t;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b00,
        FSM_XFER = 2'b01,
        FSM_FIN = 2'b10
    } hmp_fsm_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PWSET = 3'b001,
        OP_LOCK = 3'b010,
        OP_UNLOCK = 3'b011,
        OP_FREEZE = 3'b100,
        OP_SETMAX = 3'b101
    } hmp_op_t;
endpackage : hmp_pkg

// ---- rtl/hmp_try_cnt.sv ----
// Unlock attempt counter
`timescale 1ns/1ps
module hmp_try_cnt import hmp_pkg::*; #(
    parameter int W = 3
) (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic load_i, // Load value_i
    input wire logic dec_i, // Count down by one
    input wire logic [W-1:0] value_i, // Load value
    output logic [W-1:0] cnt_o // Attempts left
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } hmp_cnt_st_t;

    hmp_cnt_st_t st_reg;
    hmp_cnt_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (load_i) begin
            st_next.cnt = value_i;
        end else if (dec_i && (st_reg.cnt != '0)) begin
            // Saturate at zero so a stray decrement cannot wrap to a fresh budget
            st_next.cnt = st_reg.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cnt_o = st_reg.cnt;
endmodule : hmp_try_cnt

// ---- rtl/hmp_pw_store.sv ----
// Volatile password store and word-by-word comparator
`timescale 1ns/1ps
`include "hmp_defs.svh"
module hmp_pw_store import hmp_pkg::*; #(
    parameter int WORDS = 16,
    parameter int DW = 16
) (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic start_i, // Begin a new comparison
    input wire logic store_i, // 1: words are stored, 0: compared
    input wire logic word_valid_i, // Sector word present
    input wire logic [7:0] idx_i, // Word index in sector
    input wire logic [DW-1:0] word_i, // Sector word
    output logic match_o // All compared words equal
);
    typedef struct packed {
        logic [WORDS-1:0][DW-1:0] pw;
        logic match;
    } hmp_pw_st_t;

    hmp_pw_st_t st_reg;
    hmp_pw_st_t st_next;
    logic [WORDS-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_hit
            assign hit[g] = word_valid_i && (idx_i == 8'(g) + `HMP_PW_FIRST);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        if (start_i) begin
            st_next.match = 1'b1;
        end
        for (int i = 0; i < WORDS; i++) begin
            if (hit[i] && store_i) begin
                st_next.pw[i] = word_i;
            end else if (hit[i] && (word_i != st_reg.pw[i])) begin
                st_next.match = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign match_o = st_reg.match;
endmodule : hmp_pw_store

// ---- rtl/hmp_sec_fsm.sv ----
// Maximum-address security state machine: password, lock, unlock, freeze
// Operation
// - Opcode F9h feature 04h enters frozen on successful completion.
// - Frozen: every maximum-address command is aborted.
// - Freeze-lock arriving in unlocked state is aborted.
// - An F9h subcommand right after read-max acts as set-max.
// - Feature 02h locks; then only unlock and freeze-lock pass.
// - Locked holds until power cycle, accepted unlock or freeze-lock.
// - Password-set takes exactly one 512-byte sector from the host.
// - Words 1 to 16 carry the password; other words ignored.
// - Password kept in volatile storage until power cycle.
// - Accepted password-set makes the state unlocked.
// - Password-set while locked or frozen aborts, password unchanged.
// - Feature 03h takes one sector and compares the password words.
// - Failed unlock compare aborts and decrements the attempt counter.
// - Counter loads five on accepted lock; decrements per locked mismatch.
// - Counter at zero: unlock aborts without compare until power cycle.
// - Matching unlock enters unlocked; password-set, lock and set-max accepted again.
// - Unlock when not locked is aborted.
// - Set-max while locked or frozen is aborted.
// - Set-max not right after completed read-max is aborted.
`timescale 1ns/1ps
`include "hmp_defs.svh"
module hmp_sec_fsm import hmp_pkg::*; #(
    parameter logic DRIVE_NUM = 1'b0
) (
    input wire logic clk_i, // Clock, 100 MHz
    input wire logic arst_n_i, // Power-on reset, active low
    input wire logic cmd_valid_i, // Command written, one-cycle pulse
    input wire logic [7:0] cmd_opcode_i, // Command register
    input wire logic [7:0] cmd_feature_i, // Features register
    input wire logic cmd_drive_select_bit_i, // Drive select bit of device/head
    input wire logic rdmax_done_i, // Read-max command completed, pulse
    input wire logic data_valid_i, // Sector word from host
    input wire logic [15:0] data_i, // Sector word
    output logic busy_o, // Busy status
    output logic data_req_o, // Data request, sector words wanted
    output logic done_o, // Command completion pulse
    output logic err_o, // Status error bit
    output logic abrt_o, // Error register abort bit
    output logic setmax_go_o, // Set-max granted to address datapath, pulse
    output logic locked_o, // Locked state
    output logic frozen_o, // Frozen state
    output logic pw_valid_o, // A password is stored
    output logic [2:0] tries_left_o // Unlock attempts left
);
    typedef struct packed {
        hmp_fsm_t fsm;
        hmp_sec_t sec;
        hmp_op_t op;
        logic pw_set;
        logic prev_rd;
        logic [7:0] widx;
        logic abort_pend;
        logic busy;
        logic drq;
        logic done;
        logic err;
        logic abrt;
        logic setmax_go;
    } hmp_top_st_t;

    hmp_top_st_t st_reg;
    hmp_top_st_t st_next;
    logic take;
    logic guarded;
    logic subcmd;
    logic cnt_load;
    logic cnt_dec;
    logic pw_start;
    logic pw_match;
    logic fin_abort;
    logic [`HMP_TRY_W-1:0] tries;

    assign take = cmd_valid_i && (st_reg.fsm == FSM_IDLE) && (cmd_drive_select_bit_i == DRIVE_NUM);
    assign guarded = (cmd_opcode_i == `HMP_OPC_SETMAX) || (cmd_opcode_i == `HMP_OPC_SETMAX_EXT);
    // A subcommand is only seen as such when read-max did not just complete
    assign subcmd = (cmd_opcode_i == `HMP_OPC_SETMAX) && !st_reg.prev_rd
        && (cmd_feature_i >= `HMP_FEAT_PWSET) && (cmd_feature_i <= `HMP_FEAT_FREEZE);

    hmp_try_cnt #(
        .W(`HMP_TRY_W)
    ) u_try_cnt (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(cnt_load),
        .dec_i(cnt_dec),
        .value_i(`HMP_TRY_LOAD),
        .cnt_o(tries)
    );

    hmp_pw_store #(
        .WORDS(`HMP_PW_WORDS),
        .DW(`HMP_WORD_W)
    ) u_pw_store (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .start_i(pw_start),
        .store_i(st_reg.op == OP_PWSET),
        .word_valid_i((st_reg.fsm == FSM_XFER) && data_valid_i),
        .idx_i(st_reg.widx),
        .word_i(data_i),
        .match_o(pw_match)
    );

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.setmax_go = 1'b0;
        cnt_load = 1'b0;
        cnt_dec = 1'b0;
        pw_start = 1'b0;
        fin_abort = st_reg.abort_pend;
        // Any command ends the read-max window; a completion in the same cycle wins
        if (cmd_valid_i) begin
            st_next.prev_rd = 1'b0;
        end
        if (rdmax_done_i) begin
            st_next.prev_rd = 1'b1;
        end
        unique case (st_reg.fsm)
            FSM_IDLE: begin
                if (take && guarded) begin
                    st_next.busy = 1'b1;
                    st_next.err = 1'b0;
                    st_next.abrt = 1'b0;
                    st_next.widx = '0;
                    st_next.fsm = FSM_FIN;
                    st_next.abort_pend = 1'b0;
                    if (st_reg.sec == SEC_FROZEN) begin
                        st_next.op = OP_NONE;
                        st_next.abort_pend = 1'b1;
                    end else if (!subcmd) begin
                        st_next.op = OP_SETMAX;
                        st_next.abort_pend = (st_reg.sec == SEC_LOCKED) || !st_reg.prev_rd;
                    end else if (cmd_feature_i == `HMP_FEAT_PWSET) begin
                        st_next.op = OP_PWSET;
                        if (st_reg.sec == SEC_LOCKED) begin
                            st_next.abort_pend = 1'b1;
                        end else begin
                            st_next.drq = 1'b1;
                            st_next.fsm = FSM_XFER;
                        end
                    end else if (cmd_feature_i == `HMP_FEAT_LOCK) begin
                        st_next.op = OP_LOCK;
                        st_next.abort_pend = (st_reg.sec == SEC_LOCKED) || !st_reg.pw_set;
                    end else if (cmd_feature_i == `HMP_FEAT_UNLOCK) begin
                        st_next.op = OP_UNLOCK;
                        if ((st_reg.sec != SEC_LOCKED) || (tries == `HMP_TRY_ZERO)) begin
                            st_next.abort_pend = 1'b1;
                        end else begin
                            st_next.drq = 1'b1;
                            st_next.fsm = FSM_XFER;
                            pw_start = 1'b1;
                        end
                    end else begin
                        st_next.op = OP_FREEZE;
                        // Only a locked drive can freeze, so a password must exist
                        st_next.abort_pend = (st_reg.sec != SEC_LOCKED);
                    end
                end
            end
            FSM_XFER: begin
                if (data_valid_i) begin
                    st_next.widx = st_reg.widx + 8'h01;
                    if (st_reg.widx == `HMP_SECTOR_LAST) begin
                        st_next.drq = 1'b0;
                        st_next.fsm = FSM_FIN;
                    end
                end
            end
            FSM_FIN: begin
                if (!st_reg.abort_pend) begin
                    unique case (st_reg.op)
                        OP_PWSET: begin
                            st_next.sec = SEC_OPEN;
                            st_next.pw_set = 1'b1;
                        end
                        OP_LOCK: begin
                            st_next.sec = SEC_LOCKED;
                            cnt_load = 1'b1;
                        end
                        OP_UNLOCK: begin
                            if (pw_match) begin
                                st_next.sec = SEC_OPEN;
                            end else begin
                                fin_abort = 1'b1;
                                cnt_dec = 1'b1;
                            end
                        end
                        OP_FREEZE: begin
                            st_next.sec = SEC_FROZEN;
                        end
                        OP_SETMAX: begin
                            st_next.setmax_go = 1'b1;
                        end
                        OP_NONE: begin
                            st_next.sec = st_reg.sec;
                        end
                        default: begin
                            st_next.sec = st_reg.sec;
                        end
                    endcase
                end
                // Error bits and busy change together so the host never sees a stale status
                st_next.err = fin_abort;
                st_next.abrt = fin_abort;
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.fsm = FSM_IDLE;
            end
            default: begin
                st_next.fsm = FSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg.busy;
    assign data_req_o = st_reg.drq;
    assign done_o = st_reg.done;
    assign err_o = st_reg.err;
    assign abrt_o = st_reg.abrt;
    assign setmax_go_o = st_reg.setmax_go;
    // Locked and frozen codes own one bit each, so these flags are plain flop bits
    assign locked_o = st_reg.sec[0];
    assign frozen_o = st_reg.sec[1];
    assign pw_valid_o = st_reg.pw_set;
    assign tries_left_o = tries;

    AST_FREEZE_ENTERS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && subcmd && (cmd_feature_i == `HMP_FEAT_FREEZE) && (st_reg.sec == SEC_LOCKED)
        |=> ##1 (st_reg.sec == SEC_FROZEN) && st_reg.done && !st_reg.abrt)
        else $error("freeze-lock did not enter frozen");

    AST_FROZEN_REJECTS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && guarded && (st_reg.sec == SEC_FROZEN)
        |=> !st_reg.drq ##1 (st_reg.done && st_reg.abrt && (st_reg.sec == SEC_FROZEN)))
        else $error("command accepted while frozen");

    AST_FREEZE_OPEN_ABORT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && subcmd && (cmd_feature_i == `HMP_FEAT_FREEZE) && (st_reg.sec == SEC_OPEN)
        |=> ##1 (st_reg.abrt && (st_reg.sec == SEC_OPEN)))
        else $error("freeze-lock not aborted in unlocked state");

    AST_LOCK_LOADS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && subcmd && (cmd_feature_i == `HMP_FEAT_LOCK) && (st_reg.sec == SEC_OPEN) && st_reg.pw_set
        |=> ##1 (locked_o && (tries == `HMP_TRY_LOAD)))
        else $error("lock did not load five attempts");

    AST_ONE_SECTOR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_reg.fsm == FSM_XFER) && data_valid_i && (st_reg.widx == `HMP_SECTOR_LAST)
        |=> !st_reg.drq && st_reg.busy ##1 (st_reg.done && !st_reg.busy))
        else $error("sector length wrong");

    AST_PWSET_LOCKED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && subcmd && (cmd_feature_i == `HMP_FEAT_PWSET) && (st_reg.sec == SEC_LOCKED)
        |=> !st_reg.drq ##1 (st_reg.abrt && locked_o))
        else $error("password-set accepted while locked");

    AST_UNLOCK_GUARD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && subcmd && (cmd_feature_i == `HMP_FEAT_UNLOCK) && ((st_reg.sec != SEC_LOCKED) || (tries == '0))
        |=> !st_reg.drq ##1 (st_reg.done && st_reg.abrt))
        else $error("unlock not aborted");

    AST_MISMATCH_DEC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_reg.fsm == FSM_FIN) && (st_reg.op == OP_UNLOCK) && !st_reg.abort_pend && !pw_match
        |=> (st_reg.abrt && locked_o && (tries == $past(tries) - 3'h1)))
        else $error("mismatching unlock not aborted and counted");

    AST_SETMAX_ORDER: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        take && (cmd_opcode_i == `HMP_OPC_SETMAX_EXT) && !st_reg.prev_rd
        |=> ##1 (st_reg.abrt && !st_reg.setmax_go))
        else $error("set-max without read-max accepted");

    AST_ABORT_REPORT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        st_reg.done |-> !st_reg.busy && $past(st_reg.busy) && (st_reg.err == st_reg.abrt))
        else $error("completion status inconsistent");

    AST_PWSET_OPENS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_reg.fsm == FSM_FIN) && (st_reg.op == OP_PWSET) && !st_reg.abort_pend
        |=> st_reg.pw_set && (st_reg.sec == SEC_OPEN) && st_reg.done && !st_reg.abrt)
        else $error("accepted password-set did not unlock");

    AST_UNLOCK_MATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_reg.fsm == FSM_FIN) && (st_reg.op == OP_UNLOCK) && !st_reg.abort_pend && pw_match
        |=> (st_reg.sec == SEC_OPEN) && st_reg.done && !st_reg.abrt && (tries == $past(tries)))
        else $error("matching unlock did not unlock");

    AST_TRIES_STAY_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (tries == `HMP_TRY_ZERO) && !((st_reg.fsm == FSM_FIN) && (st_reg.op == OP_LOCK) && !st_reg.abort_pend)
        |=> (tries == `HMP_TRY_ZERO))
        else $error("exhausted attempt counter changed");

    AST_LOCKED_HOLDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        locked_o && !((st_reg.fsm == FSM_FIN) && !fin_abort && ((st_reg.op == OP_UNLOCK) || (st_reg.op == OP_FREEZE)))
        |=> locked_o)
        else $error("locked state left without an accepted unlock or freeze");
endmodule : hmp_sec_fsm

// ---- verification/hmp_host_model.sv ----
// Host adapter model: writes task-file commands and supplies one data sector
`timescale 1ns/1ps
module hmp_host_model (
    input wire logic clk_i, // Clock
    input wire logic data_req_i, // Device wants sector words
    input wire logic done_i, // Completion pulse
    input wire logic busy_i, // Busy status
    input wire logic err_i, // Status error bit
    input wire logic abrt_i, // Abort bit
    input wire logic go_i, // Set-max grant
    output logic cmd_valid_o, // Command strobe
    output logic [7:0] opcode_o, // Command register
    output logic [7:0] feature_o, // Features register
    output logic drive_select_bit_o, // Drive select bit
    output logic rdmax_done_o, // Read-max completed pulse
    output logic data_valid_o, // Sector word present
    output logic [15:0] data_o // Sector word
);
    initial begin
        cmd_valid_o = 1'b0;
        opcode_o = 8'h00;
        feature_o = 8'h00;
        drive_select_bit_o = 1'b0;
        rdmax_done_o = 1'b0;
        data_valid_o = 1'b0;
        data_o = 16'h0000;
    end

    // Returns {busy, err, abrt, go} sampled in the completion cycle
    task automatic command(input logic [7:0] op, input logic [7:0] feat, input logic rdmax, input logic drv,
            input logic [7:0] key, input logic [7:0] junk, output logic got, output logic [3:0] res);
        int idx;
        idx = 0;
        got = 1'b0;
        res = 4'h0;
        if (rdmax) begin
            @(posedge clk_i);
            rdmax_done_o <= 1'b1;
        end
        @(posedge clk_i);
        rdmax_done_o <= 1'b0;
        cmd_valid_o <= 1'b1;
        opcode_o <= op;
        feature_o <= feat;
        drive_select_bit_o <= drv;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        opcode_o <= ~op;
        feature_o <= ~feat;
        for (int n = 0; n < 600 && !got; n++) begin
            @(posedge clk_i);
            if (done_i === 1'b1) begin
                got = 1'b1;
                res = {busy_i, err_i, abrt_i, go_i};
            end
            // Exactly one sector, then the line no longer holds a word
            if (data_req_i === 1'b1 && idx < 256) begin
                data_valid_o <= 1'b1;
                data_o <= (idx >= 1 && idx <= 16) ? {key, idx[7:0]} : {junk, idx[7:0]};
                idx++;
            end else begin
                data_valid_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
    endtask : command
endmodule : hmp_host_model

// ---- verification/testbench.sv ----
// Self-checking testbench of the maximum-address security state machine
`timescale 1ns/1ps
`include "hmp_defs.svh"
module testbench;
    localparam logic [3:0] r_ok = 4'h0;
    localparam logic [3:0] r_abt = 4'h6;
    localparam logic [3:0] r_go = 4'h1;
    localparam logic [3:0] r_none = 4'hf;
    logic clk;
    logic arst_n;
    logic cmd_valid;
    logic [7:0] opcode;
    logic [7:0] feature;
    logic drv;
    logic rdmax_done;
    logic data_valid;
    logic [15:0] data;
    logic busy, data_req, done, err, abrt, go, locked, frozen, pw_valid;
    logic [2:0] tries;
    logic [7:0] st;
    int errors = 0;
    int n_compared = 0;

    assign st = {1'b0, locked, frozen, pw_valid, 1'b0, tries};

    hmp_sec_fsm #(.DRIVE_NUM(1'b0)) DUT (.clk_i(clk), .arst_n_i(arst_n), .cmd_valid_i(cmd_valid),
        .cmd_opcode_i(opcode), .cmd_feature_i(feature), .cmd_drive_select_bit_i(drv),
        .rdmax_done_i(rdmax_done), .data_valid_i(data_valid), .data_i(data), .busy_o(busy),
        .data_req_o(data_req), .done_o(done), .err_o(err), .abrt_o(abrt), .setmax_go_o(go),
        .locked_o(locked), .frozen_o(frozen), .pw_valid_o(pw_valid), .tries_left_o(tries));

    hmp_host_model host (.clk_i(clk), .data_req_i(data_req), .done_i(done), .busy_i(busy), .err_i(err),
        .abrt_i(abrt), .go_i(go), .cmd_valid_o(cmd_valid), .opcode_o(opcode), .feature_o(feature),
        .drive_select_bit_o(drv), .rdmax_done_o(rdmax_done), .data_valid_o(data_valid), .data_o(data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Reserved words differ per feature so only words 1..16 can make a match
    task automatic run(input logic [7:0] op, input logic [7:0] feat, input logic rd, input logic [7:0] key,
            input logic [3:0] exp);
        logic got;
        logic [3:0] res;
        host.command(op, feat, rd, 1'b0, key, key ^ feat ^ 8'h80, got, res);
        chk({4'h0, (got === 1'b1) ? res : r_none}, {4'h0, exp});
    endtask : run

    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task automatic t_reset;
        chk(st, 8'h00);
        chk({busy, data_req, done, err, abrt, go, 2'b00}, 8'h00);
    endtask : t_reset

    task automatic t_open;
        run(`HMP_OPC_SETMAX, `HMP_FEAT_FREEZE, 1'b0, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_UNLOCK, 1'b0, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b0, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b0, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b1, 8'h00, r_go);
        run(8'hc6, 8'h00, 1'b1, 8'h00, r_none);
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b0, 8'h00, r_abt);
        chk(st, 8'h00);
    endtask : t_open

    task automatic t_pwset;
        run(`HMP_OPC_SETMAX, `HMP_FEAT_PWSET, 1'b0, 8'h5a, r_ok);
        chk(st, 8'h10);
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b1, 8'h00, r_go);
    endtask : t_pwset

    task automatic t_lock;
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b0, 8'h00, r_ok);
        chk(st, 8'h55);
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b1, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_PWSET, 1'b0, 8'h77, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b0, 8'h00, r_abt);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_UNLOCK, 1'b0, 8'h33, r_abt);
        chk(st, 8'h54);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_UNLOCK, 1'b0, 8'h5a, r_ok);
        chk(st, 8'h14);
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b1, 8'h00, r_go);
    endtask : t_lock

    task automatic t_exhaust;
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b0, 8'h00, r_ok);
        for (int i = 0; i < 5; i++) begin
            run(`HMP_OPC_SETMAX, `HMP_FEAT_UNLOCK, 1'b0, 8'h21, r_abt);
        end
        chk(st, 8'h50);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_UNLOCK, 1'b0, 8'h5a, r_abt);
        chk(st, 8'h50);
    endtask : t_exhaust

    task automatic t_freeze;
        run(`HMP_OPC_SETMAX, `HMP_FEAT_FREEZE, 1'b0, 8'h00, r_ok);
        chk(st & 8'hf0, 8'h30);
        for (logic [7:0] f = 8'h01; f <= 8'h04; f++) begin
            run(`HMP_OPC_SETMAX, f, 1'b0, 8'h5a, r_abt);
        end
        run(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b1, 8'h00, r_abt);
        chk(st & 8'hf0, 8'h30);
    endtask : t_freeze

    // A command addressed to the other drive must get no answer at all
    task automatic t_other_drive;
        logic got;
        logic [3:0] res;
        host.command(`HMP_OPC_SETMAX_EXT, 8'h00, 1'b1, 1'b1, 8'h00, 8'h00, got, res);
        chk({7'h00, got}, 8'h00);
    endtask : t_other_drive

    task automatic t_power;
        do_reset();
        chk(st, 8'h00);
        run(`HMP_OPC_SETMAX, `HMP_FEAT_LOCK, 1'b0, 8'h00, r_abt);
    endtask : t_power

    task automatic complete_run;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // About 3400 cycles expected; some seventeen times that means a hang
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        do_reset();
        t_reset();
        t_open();
        t_pwset();
        t_other_drive();
        t_lock();
        t_exhaust();
        t_freeze();
        t_power();
        complete_run();
    end
endmodule : testbench
